/* verilog/prsr_slot_regs.sv */
// slot, root and second-generation capability register bank of a root port
`timescale 1ns/1ps

// Behaviour
// - button event gated by its enable
// - fault and latch events have own enables
// - command completion raises hot-plug interrupt when enabled
// - master enable gates the hot-plug interrupt, not the button wake
// - lamp fields drive lamps, read back state
// - power bit sets power, reads applied power
// - writing one toggles the interlock
// - link active change notifies when enabled
// - sticky status on each hot-plug event
// - live latch, presence and interlock levels
// - link active change sets sticky status
// - three enables escalate errors to system error
// - pme message interrupts when enabled
// - retry visibility enable, capability reads one
// - pme source id, status and pending
// - timeout select, timeout off, routing forward
// - target speed field caps link speed
// - compliance force, modified pattern, skip sets
// - bit disables autonomous speed change
// - pattern de-emphasis only above 2.5 GT/s
// - live and selectable de-emphasis read-only bits
// - power cap, scale, slot number, no-completion bit
module prsr_slot_regs #(
  parameter logic HOTPLUG_CAPABLE = 1'b0,
  parameter logic INTERLOCK_PRESENT = 1'b0,
  parameter logic NO_CMD_DONE_SUPPORT = 1'b1,
  parameter logic [12:0] SLOT_NUMBER = 13'h0000,
  parameter logic LINK_ACTIVE_REPORTING = 1'b1,
  parameter logic DEEMPH_CHOICE = 1'b0,
  parameter logic [31:0] DEV_CAP_TWO = 32'h00000000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  input wire logic button_pin,
  input wire logic power_fault_pin,
  input wire logic latch_sensor_pin,
  input wire logic presence_pin,
  input wire logic interlock_sense_pin,
  input wire logic power_sense_pin,
  input wire logic cmd_done,
  input wire logic link_active,
  input wire logic err_correctable_msg,
  input wire logic err_nonfatal_msg,
  input wire logic err_fatal_msg,
  input wire logic pme_msg,
  input wire logic [15:0] pme_source_id,
  input wire logic link_at_5gt,
  input wire logic phy_deemph_level,
  output logic [1:0] attention_lamp_ctrl,
  output logic [1:0] power_lamp_ctrl,
  output logic slot_power_ctrl,
  output logic interlock_toggle,
  output logic slot_cmd_issued,
  output logic hotplug_irq,
  output logic hotplug_wake,
  output logic system_error,
  output logic pme_irq,
  output logic retry_visible_enable,
  output logic [3:0] completion_timeout_sel,
  output logic completion_timeout_off,
  output logic alt_routing_fwd_enable,
  output logic [3:0] target_link_speed,
  output logic force_compliance,
  output logic auto_speed_change_off,
  output logic [2:0] tx_margin,
  output logic modified_pattern_select,
  output logic skip_sets_in_pattern,
  output logic tx_compliance_deemph
);
  // ---------------------------------------------------------------
  // configuration write decode
  // ---------------------------------------------------------------
  logic [31:0] wmask;
  logic hit_cap, hit_slot, hit_root, hit_pme, hit_dev2, hit_link2;
  assign wmask = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                  {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
  assign hit_cap = cfg_addr[11:2] == prsr_pkg::OFF_SLOT_CAP_UPPER[11:2];
  assign hit_slot = cfg_addr[11:2] == prsr_pkg::OFF_SLOT_CONTROL[11:2];
  assign hit_root = cfg_addr[11:2] == prsr_pkg::OFF_ROOT_CONTROL[11:2];
  assign hit_pme = cfg_addr[11:2] == prsr_pkg::OFF_ROOT_STATUS[11:2];
  assign hit_dev2 = cfg_addr[11:2] == prsr_pkg::OFF_DEV_CONTROL_TWO[11:2];
  assign hit_link2 = cfg_addr[11:2] == prsr_pkg::OFF_LINK_CONTROL_TWO[11:2];

  // ---------------------------------------------------------------
  // slot pins: two-stage synchroniser, then a compare stage
  // ---------------------------------------------------------------
  logic [5:0] pin_meta, pin_sync, pin_prev;
  logic [2:0] pin_primed;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      pin_prev <= 6'h00;
      pin_primed <= 3'h0;
    end else begin
      pin_meta <= {power_sense_pin, interlock_sense_pin, presence_pin,
                   latch_sensor_pin, power_fault_pin, button_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      pin_primed <= {pin_primed[1:0], 1'b1};
    end
  end

  // pin edges are ignored until the pipeline holds real pin levels, so the
  // levels present at reset release do not look like a change
  logic button_press, fault_rise, latch_change, presence_change;
  logic link_prev, link_change;
  assign button_press = pin_primed[2] & pin_sync[0] & ~pin_prev[0];
  assign fault_rise = pin_primed[2] & pin_sync[1] & ~pin_prev[1];
  assign latch_change = pin_primed[2] & (pin_sync[2] ^ pin_prev[2]);
  assign presence_change = pin_primed[2] & (pin_sync[3] ^ pin_prev[3]);
  assign link_change = LINK_ACTIVE_REPORTING & (link_active ^ link_prev);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      link_prev <= 1'b0;
    end else begin
      link_prev <= link_active;
    end
  end

  // ---------------------------------------------------------------
  // slot control
  // ---------------------------------------------------------------
  logic [15:0] slot_ctl, slot_ctl_m;
  assign slot_ctl_m = wmask[15:0] & {16{cfg_wr & hit_slot}} & prsr_pkg::SLOT_CONTROL_RW_MASK;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      slot_ctl <= prsr_pkg::SLOT_CONTROL_RST;
    end else begin
      slot_ctl <= (slot_ctl & ~slot_ctl_m) | (cfg_wdata[15:0] & slot_ctl_m);
    end
  end
  assign attention_lamp_ctrl = slot_ctl[prsr_pkg::SC_ATTN_LAMP +: 2];
  assign power_lamp_ctrl = slot_ctl[prsr_pkg::SC_POWER_LAMP +: 2];
  assign slot_power_ctrl = slot_ctl[prsr_pkg::SC_POWER];

  // interlock is a write-one pulse, the bit itself is not stored
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      interlock_toggle <= 1'b0;
      slot_cmd_issued <= 1'b0;
    end else begin
      interlock_toggle <= INTERLOCK_PRESENT & cfg_wr & hit_slot & cfg_byte_en[1]
                          & cfg_wdata[prsr_pkg::SC_INTERLOCK];
      slot_cmd_issued <= cfg_wr & hit_slot & (|cfg_byte_en[1:0]);
    end
  end

  // ---------------------------------------------------------------
  // slot status: sticky events, set beats a same-cycle clear
  // ---------------------------------------------------------------
  logic [15:0] slot_evt, slot_set, slot_clr, slot_evt_en, slot_live;
  assign slot_set = {7'h00, link_change, 3'h0, cmd_done, presence_change,
                     latch_change, fault_rise, button_press};
  assign slot_clr = cfg_wdata[31:16] & wmask[31:16] & {16{cfg_wr & hit_slot}};
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      slot_evt <= prsr_pkg::SLOT_STATUS_RST;
    end else begin
      slot_evt <= ((slot_evt & ~slot_clr) | slot_set)
                  & prsr_pkg::SLOT_STATUS_EVENT_MASK;
    end
  end
  assign slot_live = {7'h00, 1'b0, INTERLOCK_PRESENT & pin_sync[4], pin_sync[3],
                      pin_sync[2], 5'h00};

  // status bit i pairs with control bit i, link change pairs with its own enable
  assign slot_evt_en = {7'h00, slot_ctl[prsr_pkg::SC_LINK_CHG_EN] & LINK_ACTIVE_REPORTING,
                        3'h0, slot_ctl[4:0]};
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hotplug_irq <= 1'b0;
      hotplug_wake <= 1'b0;
    end else begin
      hotplug_irq <= slot_ctl[prsr_pkg::SC_MASTER_EN] & (|(slot_evt & slot_evt_en));
      hotplug_wake <= slot_evt[0] & slot_ctl[0];
    end
  end

  // ---------------------------------------------------------------
  // root control and error escalation
  // ---------------------------------------------------------------
  logic [15:0] root_ctl, root_ctl_m;
  assign root_ctl_m = wmask[15:0] & {16{cfg_wr & hit_root}} & prsr_pkg::ROOT_CONTROL_RW_MASK;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      root_ctl <= prsr_pkg::ROOT_CONTROL_RST;
      system_error <= 1'b0;
    end else begin
      root_ctl <= (root_ctl & ~root_ctl_m) | (cfg_wdata[15:0] & root_ctl_m);
      system_error <= |({err_fatal_msg, err_nonfatal_msg, err_correctable_msg}
                        & root_ctl[2:0]);
    end
  end
  assign retry_visible_enable = root_ctl[prsr_pkg::RC_RETRY_VIS]
                                & prsr_pkg::ROOT_CAP_RST[0];

  // ---------------------------------------------------------------
  // pme capture: one message may wait behind a set status bit
  // ---------------------------------------------------------------
  logic [15:0] pme_id, pme_held_id;
  logic pme_status, another_pme_waiting, pme_clr, pme_left;
  assign pme_clr = cfg_wr & hit_pme & cfg_byte_en[2] & cfg_wdata[prsr_pkg::RS_PME_STATUS];
  assign pme_left = pme_status & ~pme_clr;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pme_id <= 16'h0000;
      pme_held_id <= 16'h0000;
      pme_status <= 1'b0;
      another_pme_waiting <= 1'b0;
    end else if (pme_left) begin
      if (pme_msg) begin
        another_pme_waiting <= 1'b1;
        pme_held_id <= pme_source_id;
      end
    end else if (another_pme_waiting) begin
      // a clear while one waits promotes the waiting id at once
      pme_id <= pme_held_id;
      pme_status <= 1'b1;
      another_pme_waiting <= pme_msg;
      if (pme_msg) begin
        pme_held_id <= pme_source_id;
      end
    end else if (pme_msg) begin
      pme_id <= pme_source_id;
      pme_status <= 1'b1;
    end else begin
      pme_status <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pme_irq <= 1'b0;
    end else begin
      pme_irq <= root_ctl[prsr_pkg::RC_PME_IRQ_EN] & pme_status;
    end
  end

  // ---------------------------------------------------------------
  // slot capabilities upper, device and link control two
  // ---------------------------------------------------------------
  logic [31:0] cap_rw, cap_m, cap_ro;
  logic [15:0] dev_ctl2, dev_ctl2_m, link_ctl2, link_ctl2_m;
  assign cap_m = wmask & {32{cfg_wr & hit_cap}} & prsr_pkg::CAP_RW_MASK;
  assign dev_ctl2_m = wmask[15:0] & {16{cfg_wr & hit_dev2}} & prsr_pkg::DEV_CONTROL_TWO_RW_MASK;
  assign link_ctl2_m = wmask[15:0] & {16{cfg_wr & hit_link2}}
                       & prsr_pkg::LINK_CONTROL_TWO_RW_MASK;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cap_rw <= prsr_pkg::CAP_UPPER_RST;
      dev_ctl2 <= prsr_pkg::DEV_CONTROL_TWO_RST;
      link_ctl2 <= prsr_pkg::LINK_CONTROL_TWO_RST;
    end else begin
      cap_rw <= (cap_rw & ~cap_m) | (cfg_wdata & cap_m);
      dev_ctl2 <= (dev_ctl2 & ~dev_ctl2_m) | (cfg_wdata[15:0] & dev_ctl2_m);
      link_ctl2 <= (link_ctl2 & ~link_ctl2_m) | (cfg_wdata[15:0] & link_ctl2_m);
    end
  end
  assign cap_ro = (32'(SLOT_NUMBER) << prsr_pkg::CAP_SLOT_NUMBER)
                | (32'(NO_CMD_DONE_SUPPORT) << prsr_pkg::CAP_NO_CMD_DONE)
                | (32'(INTERLOCK_PRESENT) << prsr_pkg::CAP_INTERLOCK)
                | (32'(HOTPLUG_CAPABLE) << prsr_pkg::CAP_HOTPLUG);
  assign completion_timeout_sel = dev_ctl2[3:0];
  assign completion_timeout_off = dev_ctl2[4];
  assign alt_routing_fwd_enable = dev_ctl2[5];
  assign target_link_speed = link_ctl2[prsr_pkg::LC_SPEED +: 4];
  assign force_compliance = link_ctl2[prsr_pkg::LC_COMPLIANCE];
  assign auto_speed_change_off = link_ctl2[prsr_pkg::LC_AUTO_OFF];
  assign tx_margin = link_ctl2[prsr_pkg::LC_MARGIN +: 3];
  assign modified_pattern_select = link_ctl2[prsr_pkg::LC_MOD_PATTERN];
  assign skip_sets_in_pattern = link_ctl2[prsr_pkg::LC_SKIP_SETS];

  // at 2.5 GT/s there is no de-emphasis choice, so the bit is masked off
  logic live_deemph_level;
  assign live_deemph_level = link_at_5gt & phy_deemph_level;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_compliance_deemph <= 1'b0;
    end else begin
      tx_compliance_deemph <= link_ctl2[prsr_pkg::LC_COMPLIANCE] & link_at_5gt
                              & link_ctl2[prsr_pkg::LC_PATTERN_DEEMPH];
    end
  end

  // ---------------------------------------------------------------
  // configuration read, one cycle after the request
  // ---------------------------------------------------------------
  logic [15:0] slot_ctl_rd;
  always_comb begin
    slot_ctl_rd = slot_ctl;
    slot_ctl_rd[prsr_pkg::SC_POWER] = pin_sync[5];
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h00000000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd;
      if (cfg_rd) begin
        if (hit_cap) begin
          cfg_rdata <= cap_ro | cap_rw;
        end else if (hit_slot) begin
          cfg_rdata <= {slot_evt | slot_live, slot_ctl_rd};
        end else if (hit_root) begin
          cfg_rdata <= {prsr_pkg::ROOT_CAP_RST, root_ctl};
        end else if (hit_pme) begin
          cfg_rdata <= {14'h0000, another_pme_waiting, pme_status, pme_id};
        end else if (cfg_addr[11:2] == prsr_pkg::OFF_DEV_CAP_TWO[11:2]) begin
          cfg_rdata <= DEV_CAP_TWO;
        end else if (hit_dev2) begin
          cfg_rdata <= {16'h0000, dev_ctl2};
        end else if (hit_link2) begin
          cfg_rdata <= {15'h0000, live_deemph_level, link_ctl2 | (16'(DEEMPH_CHOICE)
                        << prsr_pkg::LC_DEEMPH_CHOICE)};
        end else begin
          // reserved and unmapped dwords read as zero
          cfg_rdata <= 32'h00000000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_button_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
    hotplug_wake |-> $past(slot_ctl[0]) && $past(slot_evt[0]))
    else $error("wake without enabled button event");
  chk_fault_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fault_rise |=> slot_evt[1])
    else $error("power fault event not recorded");
  chk_cmd_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cmd_done && slot_ctl[4] && slot_ctl[5] && !slot_ctl_m[4] && !slot_ctl_m[5]
    |-> ##2 hotplug_irq)
    else $error("command completion did not interrupt");
  chk_master_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !slot_ctl[prsr_pkg::SC_MASTER_EN] |=> !hotplug_irq)
    else $error("hot-plug interrupt with master enable clear");
  chk_lamp_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_wr && hit_slot && cfg_byte_en[0] |=> attention_lamp_ctrl == $past(cfg_wdata[7:6]))
    else $error("attention lamp not taken from write");
  chk_toggle_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    interlock_toggle |=> !interlock_toggle || $past(cfg_wr))
    else $error("interlock toggle longer than its write");
  chk_link_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(link_active) && LINK_ACTIVE_REPORTING |=> slot_evt[prsr_pkg::SS_LINK_CHG])
    else $error("link active change not recorded");
  chk_syserr_fatal: assert property (@(posedge sys_clk) disable iff (!reset_n)
    err_fatal_msg && root_ctl[2] |=> system_error)
    else $error("fatal error not escalated");
  chk_syserr_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    root_ctl[2:0] == 3'h0 |=> !system_error)
    else $error("system error with all enables clear");
  chk_pme_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pme_msg && !pme_status && root_ctl[3] && !root_ctl_m[3] |-> ##2 pme_irq)
    else $error("pme message did not interrupt");
  chk_another_pme_waiting: assert property (@(posedge sys_clk) disable iff (!reset_n)
    another_pme_waiting |-> pme_status)
    else $error("another_pme_waiting without pme status");
  chk_pme_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pme_status && !pme_clr |=> pme_status && $stable(pme_id))
    else $error("pme status lost without a clear");
  chk_event_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slot_evt[0] && !slot_clr[0] |=> slot_evt[0])
    else $error("button status lost without a clear");
  chk_deemph_slow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !link_at_5gt |=> !tx_compliance_deemph)
    else $error("de-emphasis select acted at 2.5 GT/s");
  chk_read_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_rd && hit_link2 && !cfg_wr |=> cfg_rd_valid && cfg_rdata[3:0] == target_link_speed)
    else $error("target speed read mismatch");

endmodule : prsr_slot_regs

/* verilog/prsr_pkg.sv */
// offsets, field positions and reset values of the root port slot register bank
package prsr_pkg;
  // ---------------------------------------------------------------
  // configuration offsets (byte addresses, 16-bit registers share a dword)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_SLOT_CAP_UPPER = 12'h06c;
  localparam logic [11:0] OFF_SLOT_CONTROL = 12'h070;
  localparam logic [11:0] OFF_SLOT_STATUS = 12'h072;
  localparam logic [11:0] OFF_ROOT_CONTROL = 12'h074;
  localparam logic [11:0] OFF_ROOT_CAP = 12'h076;
  localparam logic [11:0] OFF_ROOT_STATUS = 12'h078;
  localparam logic [11:0] OFF_DEV_CAP_TWO = 12'h07c;
  localparam logic [11:0] OFF_DEV_CONTROL_TWO = 12'h080;
  localparam logic [11:0] OFF_DEV_STATUS_TWO = 12'h082;
  localparam logic [11:0] OFF_LINK_CAP_TWO = 12'h084;
  localparam logic [11:0] OFF_LINK_CONTROL_TWO = 12'h088;
  localparam logic [11:0] OFF_LINK_STATUS_TWO = 12'h08a;
  localparam logic [11:0] OFF_SLOT_CAP_TWO = 12'h08c;
  // ---------------------------------------------------------------
  // slot capabilities, upper part
  // ---------------------------------------------------------------
  localparam int CAP_HOTPLUG = 6;
  localparam int CAP_POWER_VALUE = 7;
  localparam int CAP_POWER_SCALE = 15;
  localparam int CAP_INTERLOCK = 17;
  localparam int CAP_NO_CMD_DONE = 18;
  localparam int CAP_SLOT_NUMBER = 19;
  localparam logic [31:0] CAP_RW_MASK = 32'h0001ff80;
  localparam logic [31:0] CAP_UPPER_RST = 32'h00000000;
  // ---------------------------------------------------------------
  // slot control and slot status
  // ---------------------------------------------------------------
  localparam int SC_CMD_DONE_EN = 4;
  localparam int SC_MASTER_EN = 5;
  localparam int SC_ATTN_LAMP = 6;
  localparam int SC_POWER_LAMP = 8;
  localparam int SC_POWER = 10;
  localparam int SC_INTERLOCK = 11;
  localparam int SC_LINK_CHG_EN = 12;
  localparam logic [15:0] SLOT_CONTROL_RW_MASK = 16'h17ff;
  localparam logic [15:0] SLOT_CONTROL_RST = 16'h0000;
  localparam int SS_LATCH_LEVEL = 5;
  localparam int SS_PRESENT = 6;
  localparam int SS_INTERLOCK = 7;
  localparam int SS_LINK_CHG = 8;
  localparam logic [15:0] SLOT_STATUS_EVENT_MASK = 16'h011f;
  localparam logic [15:0] SLOT_STATUS_RST = 16'h0000;
  // ---------------------------------------------------------------
  // root control, capabilities and status
  // ---------------------------------------------------------------
  localparam int RC_PME_IRQ_EN = 3;
  localparam int RC_RETRY_VIS = 4;
  localparam logic [15:0] ROOT_CONTROL_RW_MASK = 16'h001f;
  localparam logic [15:0] ROOT_CONTROL_RST = 16'h0000;
  localparam logic [15:0] ROOT_CAP_RST = 16'h0001;
  localparam int RS_PME_STATUS = 16;
  localparam int RS_ANOTHER_PME_WAITING = 17;
  // ---------------------------------------------------------------
  // device control two and link control two
  // ---------------------------------------------------------------
  localparam logic [15:0] DEV_CONTROL_TWO_RW_MASK = 16'h003f;
  localparam logic [15:0] DEV_CONTROL_TWO_RST = 16'h0000;
  localparam int LC_SPEED = 0;
  localparam int LC_COMPLIANCE = 4;
  localparam int LC_AUTO_OFF = 5;
  localparam int LC_DEEMPH_CHOICE = 6;
  localparam int LC_MARGIN = 7;
  localparam int LC_MOD_PATTERN = 10;
  localparam int LC_SKIP_SETS = 11;
  localparam int LC_PATTERN_DEEMPH = 12;
  localparam logic [15:0] LINK_CONTROL_TWO_RW_MASK = 16'h1fbf;
  localparam logic [15:0] LINK_CONTROL_TWO_RST = 16'h0001;
endpackage : prsr_pkg

/* tb/prsr_slot_model.sv */
// behavioural slot hardware: power controller and hot-plug command engine
`timescale 1ns/1ps
module prsr_slot_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slot_power_ctrl,
  input wire logic slot_cmd_issued,
  output logic power_sense_pin,
  output logic cmd_done
);
  logic [1:0] cmd_delay;
  // answers three cycles after slot_cmd_issued so the done pulse never lines up with the write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd_delay <= 2'h0;
      cmd_done <= 1'b0;
      power_sense_pin <= 1'b0;
    end else begin
      cmd_delay <= {cmd_delay[0], slot_cmd_issued};
      cmd_done <= cmd_delay[1];
      power_sense_pin <= slot_power_ctrl;
    end
  end
endmodule : prsr_slot_model

/* tb/prsr_slot_regs_tb.sv */
// self-checking bench of the root port slot register bank
`timescale 1ns/1ps
module prsr_slot_regs_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, pme_msg = 1'b0;
  logic presence_pin = 1'b0, power_fault_pin = 1'b0, link_active = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_byte_en = 4'h0, lc_speed, dc_sel;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd, d;
  logic [15:0] pme_source_id = 16'h0, id1, id2;
  logic [2:0] err_v = 3'h0;
  logic cfg_rd_valid, slot_power_ctrl, slot_cmd_issued, power_sense_pin, cmd_done;
  logic hotplug_irq, system_error, pme_irq, tx_compliance_deemph;
  logic at5 = 1'b0, phy_lvl = 1'b0, fc, aso, mps, ssp, cto, arf, rve;
  logic [2:0] txm;
  logic [1:0] al, pl;
  int fails = 0, samples_checked = 0, seed = 32'h1890, n;
  initial forever #50 sys_clk = ~sys_clk;
  prsr_slot_regs prsr_slot_regs_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .button_pin(1'b0),
    .power_fault_pin(power_fault_pin), .latch_sensor_pin(1'b0), .presence_pin(presence_pin),
    .interlock_sense_pin(1'b0), .power_sense_pin(power_sense_pin), .cmd_done(cmd_done),
    .link_active(link_active), .err_correctable_msg(err_v[0]), .err_nonfatal_msg(err_v[1]),
    .err_fatal_msg(err_v[2]), .pme_msg(pme_msg), .pme_source_id(pme_source_id),
    .link_at_5gt(at5), .phy_deemph_level(phy_lvl), .attention_lamp_ctrl(al),
    .power_lamp_ctrl(pl), .slot_power_ctrl(slot_power_ctrl), .interlock_toggle(),
    .slot_cmd_issued(slot_cmd_issued), .hotplug_irq(hotplug_irq), .hotplug_wake(),
    .system_error(system_error), .pme_irq(pme_irq), .retry_visible_enable(rve),
    .completion_timeout_sel(dc_sel), .completion_timeout_off(cto),
    .alt_routing_fwd_enable(arf), .target_link_speed(lc_speed), .force_compliance(fc),
    .auto_speed_change_off(aso), .tx_margin(txm), .modified_pattern_select(mps),
    .skip_sets_in_pattern(ssp), .tx_compliance_deemph(tx_compliance_deemph));
  prsr_slot_model prsr_slot_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .slot_power_ctrl(slot_power_ctrl), .slot_cmd_issued(slot_cmd_issued),
    .power_sense_pin(power_sense_pin), .cmd_done(cmd_done));
  // ---------------------------------------------------------------
  // bus tasks and expectations
  // ---------------------------------------------------------------
  function automatic logic [31:0] masked(input logic [31:0] v, input logic [15:0] m);
    return {16'h0, v[15:0] & m};
  endfunction : masked
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_byte_en <= be;
    cfg_wdata <= v;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask : cfg_write
  task automatic cfg_read(input logic [11:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    if (cfg_rd_valid !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: read not answered", $time);
      close_out();
    end
    v = cfg_rdata;
  endtask : cfg_read
  task automatic pme(input logic [15:0] id);
    @(posedge sys_clk);
    pme_msg <= 1'b1;
    pme_source_id <= id;
    @(posedge sys_clk);
    pme_msg <= 1'b0;
  endtask : pme
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cfg_read(12'h06c, rd);
    check(rd, 32'h0004_0000);
    cfg_read(12'h074, rd);
    check(rd, 32'h0001_0000);
    cfg_read(12'h088, rd);
    check(rd, 32'h0000_0001);
    cfg_write(12'h084, 4'hf, 32'hffff_ffff);
    cfg_read(12'h084, rd);
    check(rd, 32'h0);
    // power on, command and master enables, then wait for the command to finish
    cfg_write(12'h070, 4'h3, 32'h0000_0430);
    n = 0;
    while (hotplug_irq !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(hotplug_irq, 32'h1);
    if (n == 20) close_out();
    cfg_write(12'h070, 4'h4, 32'h0010_0000);
    repeat (2) @(posedge sys_clk);
    #1;
    check(hotplug_irq, 32'h0);
    presence_pin <= 1'b1;
    power_fault_pin <= 1'b1;
    link_active <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cfg_read(12'h070, rd);
    check(rd, 32'h014a_0430);
    check(hotplug_irq, 32'h0);
    cfg_write(12'h074, 4'h1, 32'h0000_001f);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      err_v <= 3'h1 << i;
      @(posedge sys_clk);
      err_v <= 3'h0;
      #1;
      check(system_error, 32'h1);
    end
    check(rve, 32'h1);
    d = $random(seed);
    id1 = d[15:0];
    id2 = d[31:16];
    pme(id1);
    cfg_read(12'h078, rd);
    check(rd, {14'h0, 2'b01, id1});
    check(pme_irq, 32'h1);
    pme(id2);
    cfg_read(12'h078, rd);
    check(rd, {14'h0, 2'b11, id1});
    cfg_write(12'h078, 4'h4, 32'h0001_0000);
    cfg_read(12'h078, rd);
    check(rd, {14'h0, 2'b01, id2});
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      // corner: forced compliance with de-emphasis select at 5 GT/s
      if (i == 0) d = d | 32'h0000_7010;
      at5 <= d[13];
      phy_lvl <= d[14];
      cfg_write(12'h06c, 4'hf, d);
      cfg_read(12'h06c, rd);
      check(rd, (d & 32'h0001_ff80) | 32'h0004_0000);
      cfg_write(12'h070, 4'h3, d);
      cfg_write(12'h088, 4'h3, d);
      cfg_read(12'h088, rd);
      check(rd, masked(d, 16'h1fbf) | {15'h0, d[13] & d[14], 16'h0});
      check({20'h0, ssp, mps, txm, 1'b0, aso, fc, lc_speed}, masked(d, 16'h0fbf));
      check({28'h0, pl, al}, {28'h0, d[9:6]});
      check(tx_compliance_deemph, {31'h0, d[4] & d[12] & d[13]});
      cfg_write(12'h080, 4'h3, d);
      cfg_read(12'h080, rd);
      check(rd, masked(d, 16'h003f));
      check({26'h0, arf, cto, dc_sel}, masked(d, 16'h003f));
    end
    close_out();
  end
endmodule : prsr_slot_regs_tb
